// ==== hw/smis_top.sv ====
// smis_top: management interrupt status latches, enable gates and group routing.
// assumes sibling functions and the gpio event logic run on sys_clk; only the two
// infrared receive pins come from outside and are synchronised here.
`timescale 1ns/1ps
`default_nettype none

module smis_top (
   // clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        reset,
   // register port
   input  wire smis_pkg::smis_req_t         req,
   output logic [smis_pkg::REG_W-1:0]       rdata,
   // interrupt sources
   input  wire smis_pkg::smis_src_t         src,
   input  wire logic                        infrared_rx_primary,
   input  wire logic                        infrared_rx_alternate,
   input  wire logic                        ir_select_alternate,
   input  wire logic [smis_pkg::REG_W-1:0]  gpio_evt_c,
   input  wire logic [smis_pkg::REG_W-1:0]  gpio_evt_d,
   input  wire logic [smis_pkg::REG_W-1:0]  gpio_evt_e,
   // enables kept by neighbouring registers
   input  wire logic [smis_pkg::REG_W-1:0]  enable_c,
   input  wire logic [smis_pkg::REG_W-1:0]  enable_d,
   input  wire logic [smis_pkg::REG_W-1:0]  enable_e,
   // group routing
   output logic                             group_mgmt_interrupt,
   output logic                             power_wake_event,
   output logic                             group_serial_irq,
   output logic                             mgmt_interrupt_pin_n,
   output logic                             mgmt_interrupt_pin_oe,
   // block interrupt
   output logic                             block_irq
);
   import smis_pkg::*;

   // clear-on-one helper; a set in the same cycle wins over the clear
   function automatic logic [REG_W-1:0] w1c_next(
      input logic [REG_W-1:0] cur,
      input logic [REG_W-1:0] set,
      input logic             hit,
      input logic [REG_W-1:0] wdata,
      input logic [REG_W-1:0] mask
   );
      logic [REG_W-1:0] clr;
      clr = hit ? wdata : REG_RESET;
      return ((cur & ~clr) | set) & mask;
   endfunction

   // decode of a write to one offset
   function automatic logic wr_hit(input smis_req_t r, input logic [ADDR_W-1:0] ofs);
      return r.wr && (r.addr == ofs);
   endfunction

   logic [REG_W-1:0] status_c_q, status_c_d;
   logic [REG_W-1:0] status_d_q, status_d_d;
   logic [REG_W-1:0] status_e_q, status_e_d;
   logic [REG_W-1:0] enable_a_q;
   logic [REG_W-1:0] enable_b_q;
   logic [REG_W-1:0] evt_status_q, evt_status_d;
   logic [REG_W-1:0] evt_mask_q;
   logic [REG_W-1:0] rdata_q, rdata_d;
   logic             mouse_q, keyboard_q, kbc_line_q;
   logic             ir_flag_q, ir_flag_d;
   logic             ir_pri_meta_q, ir_pri_q;
   logic             ir_alt_meta_q, ir_alt_q;
   logic             ir_sel_prev_q;
   logic             ir_prev_valid_q;
   logic             ir_sel;
   logic             ir_edge;
   logic             ir_read_clear;
   logic [REG_W-1:0] status_a;
   logic [REG_W-1:0] status_b;
   logic             group_d;
   logic             group_q;
   logic             wake_q, serirq_q, pin_n_q, pin_oe_q, irq_q;

   // infrared pin synchronisers; first stage feeds only the second
   // no reset: the chain holds the pin level at release, so an idle-high pin gives no false edge
   always_ff @(posedge sys_clk) begin
      ir_pri_meta_q <= infrared_rx_primary;
      ir_pri_q      <= ir_pri_meta_q;
      ir_alt_meta_q <= infrared_rx_alternate;
      ir_alt_q      <= ir_alt_meta_q;
   end

   // edge detect after the input mux so a select change between differing levels also counts as a transition
   assign ir_sel  = ir_select_alternate ? ir_alt_q : ir_pri_q;
   assign ir_edge = ir_prev_valid_q && (ir_sel != ir_sel_prev_q);

   // history of the selected input; first sample after reset only primes it
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ir_sel_prev_q   <= 1'b0;
         ir_prev_valid_q <= 1'b0;
      end else begin
         ir_sel_prev_q   <= ir_sel;
         ir_prev_valid_q <= 1'b1;
      end
   end

   // infrared flag: set by edge, cleared by a read of status b, set wins
   assign ir_read_clear = req.rd && (req.addr == OFS_STATUS_B);
   always_comb begin
      ir_flag_d = ir_flag_q;
      if (ir_read_clear) begin
         ir_flag_d = 1'b0;
      end
      if (ir_edge) begin
         ir_flag_d = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ir_flag_q <= 1'b0;
      end else begin
         ir_flag_q <= ir_flag_d;
      end
   end

   // level flags follow their sources; register access has no path here
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mouse_q    <= 1'b0;
         keyboard_q <= 1'b0;
         kbc_line_q <= 1'b0;
      end else begin
         mouse_q    <= src.mouse;
         keyboard_q <= src.keyboard;
         kbc_line_q <= src.kbc_line;
      end
   end

   // status b assembled from the follow flags and the infrared latch
   always_comb begin
      status_b          = REG_RESET;
      status_b[STB_MOUSE] = mouse_q;
      status_b[STB_KBD]   = keyboard_q;
      status_b[STB_IR]    = ir_flag_q;
      status_b[STB_KBC]   = kbc_line_q;
   end

   // status a lives elsewhere; its source levels are gated here directly
   assign status_a = {2'b00, src.midi, src.floppy, src.serial_one, src.serial_two, src.parallel, 1'b0};

   // latched gpio and fan status, clear on write of one, reserved bits masked off
   assign status_c_d = w1c_next(status_c_q, gpio_evt_c & STATUS_C_MASK, wr_hit(req, OFS_STATUS_C),
                                req.wdata, STATUS_C_MASK);
   assign status_d_d = w1c_next(status_d_q, gpio_evt_d & STATUS_D_MASK, wr_hit(req, OFS_STATUS_D),
                                req.wdata, STATUS_D_MASK);
   assign status_e_d = w1c_next(status_e_q, gpio_evt_e & STATUS_E_MASK, wr_hit(req, OFS_STATUS_E),
                                req.wdata, STATUS_E_MASK);

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         status_c_q <= REG_RESET;
         status_d_q <= REG_RESET;
         status_e_q <= REG_RESET;
      end else begin
         status_c_q <= status_c_d;
         status_d_q <= status_d_d;
         status_e_q <= status_e_d;
      end
   end

   // enable registers; reserved positions never store
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         enable_a_q <= REG_RESET;
         enable_b_q <= REG_RESET;
      end else begin
         if (wr_hit(req, OFS_ENABLE_A)) begin
            enable_a_q <= req.wdata & ENABLE_A_MASK;
         end
         if (wr_hit(req, OFS_ENABLE_B)) begin
            enable_b_q <= req.wdata & ENABLE_B_MASK;
         end
      end
   end

   // group term; routing bits 5-7 of enable b are masked out of the source gate
   assign group_d = |(status_a & enable_a_q)
                  | |(status_b & enable_b_q & STATUS_B_MASK)
                  | |(status_c_q & enable_c)
                  | |(status_d_q & enable_d)
                  | |(status_e_q & enable_e);

   // routed outputs registered from the same term so they never disagree
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         group_q  <= 1'b0;
         wake_q   <= 1'b0;
         serirq_q <= 1'b0;
         pin_n_q  <= 1'b1;
         pin_oe_q <= 1'b0;
      end else begin
         group_q  <= group_d;
         wake_q   <= group_d && enable_b_q[ENB_WAKE];
         serirq_q <= group_d && enable_b_q[ENB_SERIRQ];
         pin_n_q  <= !(group_d && enable_b_q[ENB_PIN]);
         pin_oe_q <= enable_b_q[ENB_PIN];
      end
   end

   // block events: group rising and infrared edge, sticky until written with one
   always_comb begin
      evt_status_d = evt_status_q;
      if (wr_hit(req, OFS_EVT_STATUS)) begin
         evt_status_d = evt_status_d & ~req.wdata;
      end
      evt_status_d[EVT_GROUP] = evt_status_d[EVT_GROUP] | (group_d & ~group_q);
      evt_status_d[EVT_IR]    = evt_status_d[EVT_IR] | ir_edge;
      evt_status_d            = evt_status_d & EVT_MASK;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         evt_status_q <= REG_RESET;
         evt_mask_q   <= REG_RESET;
         irq_q        <= 1'b0;
      end else begin
         evt_status_q <= evt_status_d;
         if (wr_hit(req, OFS_EVT_MASK)) begin
            evt_mask_q <= req.wdata & EVT_MASK;
         end
         irq_q <= |(evt_status_d & evt_mask_q);
      end
   end

   // read mux; unmapped offsets and the gap read zero
   always_comb begin
      rdata_d = REG_RESET;
      if (req.rd) begin
         unique case (req.addr)
            OFS_STATUS_B:   rdata_d = status_b;
            OFS_STATUS_C:   rdata_d = status_c_q;
            OFS_STATUS_D:   rdata_d = status_d_q;
            OFS_STATUS_E:   rdata_d = status_e_q;
            OFS_GAP:        rdata_d = REG_RESET;
            OFS_ENABLE_A:   rdata_d = enable_a_q;
            OFS_ENABLE_B:   rdata_d = enable_b_q;
            OFS_EVT_STATUS: rdata_d = evt_status_q;
            OFS_EVT_MASK:   rdata_d = evt_mask_q;
            default:        rdata_d = REG_RESET;
         endcase
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdata_q <= REG_RESET;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign rdata                 = rdata_q;
   assign group_mgmt_interrupt  = group_q;
   assign power_wake_event      = wake_q;
   assign group_serial_irq      = serirq_q;
   assign mgmt_interrupt_pin_n  = pin_n_q;
   assign mgmt_interrupt_pin_oe = pin_oe_q;
   assign block_irq             = irq_q;

   // checks on the design's own registers and outputs
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   sequence s_read_b_quiet;
      req.rd && (req.addr == OFS_STATUS_B) && !ir_edge;
   endsequence

   sequence s_write_c;
      req.wr && (req.addr == OFS_STATUS_C);
   endsequence

   a_ir_flag_set: assert property (ir_edge |=> ir_flag_q)
      else $error("infrared flag not set after edge");

   a_ir_read_clear: assert property (s_read_b_quiet |=> !ir_flag_q && rdata_q[STB_IR] == $past(ir_flag_q))
      else $error("infrared flag read did not return old value and clear");

   a_follow_mouse: assert property (!reset |=> mouse_q == $past(src.mouse)
                                    && keyboard_q == $past(src.keyboard) && kbc_line_q == $past(src.kbc_line))
      else $error("follow flag does not track source");

   a_rsvd_bits_zero: assert property (!status_c_q[3] && status_e_q[5:4] == 2'b00 && !enable_b_q[3])
      else $error("reserved status or enable bit set");

   a_w1c_clear: assert property (s_write_c |=> (status_c_q & $past(req.wdata & ~gpio_evt_c)) == 8'h00)
      else $error("write of one did not clear status c");

   a_gap_reads_zero: assert property (req.rd && req.addr == OFS_GAP |=> rdata_q == 8'h00)
      else $error("reserved offset read nonzero");

   a_group_from_mouse: assert property (mouse_q && enable_b_q[STB_MOUSE] |=> group_mgmt_interrupt)
      else $error("enabled mouse flag did not raise group");

   a_group_quiet: assert property (enable_a_q == 8'h00 && enable_b_q == 8'h00 && enable_c == 8'h00
                                   && enable_d == 8'h00 && enable_e == 8'h00 |=> !group_mgmt_interrupt)
      else $error("group high with all enables clear");

   a_wake_route: assert property (power_wake_event |-> group_mgmt_interrupt && $past(enable_b_q[ENB_WAKE]))
      else $error("wake event without group and route enable");

   a_serirq_route: assert property (group_d && enable_b_q[ENB_SERIRQ] |=> group_serial_irq)
      else $error("serial irq route missed group");

   a_pin_drive: assert property (!reset |=> mgmt_interrupt_pin_oe == $past(enable_b_q[ENB_PIN])
                                 && (mgmt_interrupt_pin_n || group_mgmt_interrupt))
      else $error("pin drive does not match route enable");

   a_reset_values: assert property ($past(reset) |-> enable_a_q == 8'h00 && enable_b_q == 8'h00
                                    && status_c_q == 8'h00 && status_d_q == 8'h00 && status_e_q == 8'h00
                                    && !ir_flag_q && !group_mgmt_interrupt && mgmt_interrupt_pin_n
                                    && !mgmt_interrupt_pin_oe)
      else $error("register not cleared by reset");

   // latching, clearing and gating checks
   sequence s_write_zero_d;
      req.wr && (req.addr == OFS_STATUS_D) && (req.wdata == 8'h00);
   endsequence

   a_latch_c: assert property (gpio_evt_c != 8'h00
                               |=> (~status_c_q & $past(gpio_evt_c & STATUS_C_MASK)) == 8'h00)
      else $error("gpio event lost in status c");

   a_latch_d: assert property (gpio_evt_d != 8'h00
                               |=> (~status_d_q & $past(gpio_evt_d & STATUS_D_MASK)) == 8'h00)
      else $error("gpio event lost in status d");

   a_latch_e: assert property (gpio_evt_e != 8'h00
                               |=> (~status_e_q & $past(gpio_evt_e & STATUS_E_MASK)) == 8'h00)
      else $error("gpio or fan event lost in status e");

   a_w1c_zero_keep: assert property (s_write_zero_d
                                     |=> status_d_q == $past(status_d_q | (gpio_evt_d & STATUS_D_MASK)))
      else $error("write of zero changed status d");

   a_ir_sticky: assert property (ir_flag_q && !(req.rd && req.addr == OFS_STATUS_B) |=> ir_flag_q)
      else $error("infrared flag cleared without a read");

   a_enable_a_store: assert property (wr_hit(req, OFS_ENABLE_A)
                                      |=> enable_a_q == $past(req.wdata & ENABLE_A_MASK))
      else $error("enable a did not store implemented bits");

   a_enable_b_store: assert property (wr_hit(req, OFS_ENABLE_B)
                                      |=> enable_b_q == $past(req.wdata & ENABLE_B_MASK))
      else $error("enable b did not store implemented bits");

   a_group_from_a: assert property ((status_a & enable_a_q) != 8'h00 |=> group_mgmt_interrupt)
      else $error("enabled sibling interrupt did not raise group");

   a_group_from_c: assert property ((status_c_q & enable_c) != 8'h00 |=> group_mgmt_interrupt)
      else $error("enabled status c bit did not raise group");

   a_serirq_off: assert property (!enable_b_q[ENB_SERIRQ] |=> !group_serial_irq)
      else $error("serial irq route active while disabled");

   a_pin_idle_high: assert property (!mgmt_interrupt_pin_oe |-> mgmt_interrupt_pin_n)
      else $error("pin drive low while not routed");

endmodule

`default_nettype wire

// ==== hw/smis_pkg.sv ====
// smis_pkg: constants and carrier types for the management interrupt status/enable block.
// assumes one 100 MHz clock domain and an 8-bit register port with byte offsets.
package smis_pkg;

   // register port widths
   localparam int unsigned REG_W  = 8;
   localparam int unsigned ADDR_W = 8;

   // register offsets
   localparam logic [ADDR_W-1:0] OFS_STATUS_B   = 8'h11;
   localparam logic [ADDR_W-1:0] OFS_STATUS_C   = 8'h12;
   localparam logic [ADDR_W-1:0] OFS_STATUS_D   = 8'h13;
   localparam logic [ADDR_W-1:0] OFS_STATUS_E   = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_GAP        = 8'h15;
   localparam logic [ADDR_W-1:0] OFS_ENABLE_A   = 8'h16;
   localparam logic [ADDR_W-1:0] OFS_ENABLE_B   = 8'h17;
   localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_EVT_MASK   = 8'h21;

   // status b field positions
   localparam int unsigned STB_MOUSE = 0;
   localparam int unsigned STB_KBD   = 1;
   localparam int unsigned STB_IR    = 2;
   localparam int unsigned STB_KBC   = 4;

   // enable b routing positions
   localparam int unsigned ENB_WAKE   = 5;
   localparam int unsigned ENB_SERIRQ = 6;
   localparam int unsigned ENB_PIN    = 7;

   // implemented-bit masks, reserved positions are zero
   localparam logic [REG_W-1:0] STATUS_B_MASK = 8'h17;
   localparam logic [REG_W-1:0] STATUS_C_MASK = 8'hf7;
   localparam logic [REG_W-1:0] STATUS_D_MASK = 8'hff;
   localparam logic [REG_W-1:0] STATUS_E_MASK = 8'hcf;
   localparam logic [REG_W-1:0] ENABLE_A_MASK = 8'h3e;
   localparam logic [REG_W-1:0] ENABLE_B_MASK = 8'hf7;

   // block event register layout
   localparam int unsigned      EVT_GROUP = 0;
   localparam int unsigned      EVT_IR    = 1;
   localparam logic [REG_W-1:0] EVT_MASK  = 8'h03;

   // value of every register after reset
   localparam logic [REG_W-1:0] REG_RESET = 8'h00;

   // one register port access
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [REG_W-1:0]  wdata;
      logic              wr;
      logic              rd;
   } smis_req_t;

   // interrupt levels from sibling functions, same clock
   typedef struct packed {
      logic mouse;
      logic keyboard;
      logic kbc_line;
      logic parallel;
      logic serial_two;
      logic serial_one;
      logic floppy;
      logic midi;
   } smis_src_t;

endpackage

// ==== dv/tb_top.sv ====
// tb_top: self-checking bench for the management interrupt status and enable block.
// assumes smis_pkg and smis_top are compiled first; one 100 MHz clock, sync reset.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import smis_pkg::*;

   logic             sys_clk   = 1'b0;
   logic             reset     = 1'b1;
   smis_req_t        req       = '0;
   smis_src_t        src       = '0;
   logic             ir_pri    = 1'b0;
   logic             ir_alt    = 1'b0;
   logic             ir_sel    = 1'b0;
   logic [REG_W-1:0] evt [3]   = '{default: 8'h00};
   logic [REG_W-1:0] en_x [3]  = '{default: 8'h00};
   logic [REG_W-1:0] smask [3] = '{STATUS_C_MASK, STATUS_D_MASK, STATUS_E_MASK};
   logic [REG_W-1:0] rdata;
   logic             grp, wake, serirq, pin_n, pin_oe, block_irq;
   int               fails     = 0;
   int               n_tests   = 0;

   // 100 MHz clock
   always #5 sys_clk = ~sys_clk;

   smis_top dut (
      .sys_clk              (sys_clk),
      .reset                (reset),
      .req                  (req),
      .rdata                (rdata),
      .src                  (src),
      .infrared_rx_primary  (ir_pri),
      .infrared_rx_alternate(ir_alt),
      .ir_select_alternate  (ir_sel),
      .gpio_evt_c           (evt[0]),
      .gpio_evt_d           (evt[1]),
      .gpio_evt_e           (evt[2]),
      .enable_c             (en_x[0]),
      .enable_d             (en_x[1]),
      .enable_e             (en_x[2]),
      .group_mgmt_interrupt (grp),
      .power_wake_event     (wake),
      .group_serial_irq     (serirq),
      .mgmt_interrupt_pin_n (pin_n),
      .mgmt_interrupt_pin_oe(pin_oe),
      .block_irq            (block_irq)
   );

   // register and flag comparisons
   task automatic chk8(input string what, input logic [REG_W-1:0] exp, input logic [REG_W-1:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask

   // sample just after an edge so all updates have landed
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1;
      chk8(what, exp, rdata);
   endtask

   // routing outputs; pin is low only when group is up and routed
   task automatic outs(input logic g, input logic w, input logic s, input logic oe);
      chk1("group", g, grp);
      chk1("wake", w, wake);
      chk1("serirq", s, serirq);
      chk1("pin_oe", oe, pin_oe);
      chk1("pin_n", !(g && oe), pin_n);
   endtask

   task automatic t_reset();
      for (int a = 8'h11; a <= 8'h17; a++) rd_chk("reset value", 8'(a), REG_RESET);
      rd_chk("event mask", OFS_EVT_MASK, REG_RESET);
      outs(1'b0, 1'b0, 1'b0, 1'b0);
      reg_wr(OFS_GAP, 8'hff);
      rd_chk("gap", OFS_GAP, 8'h00);
      reg_wr(8'h30, 8'hff);
      rd_chk("unmapped", 8'h30, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_enables();
      reg_wr(OFS_ENABLE_A, 8'hff);
      rd_chk("enable a", OFS_ENABLE_A, ENABLE_A_MASK);
      reg_wr(OFS_ENABLE_B, 8'hff);
      rd_chk("enable b", OFS_ENABLE_B, ENABLE_B_MASK);
      reg_wr(OFS_ENABLE_A, 8'h00);
      reg_wr(OFS_ENABLE_B, 8'h00);
      $display("test enables done");
   endtask

   task automatic t_status_b();
      @(posedge sys_clk);
      src <= '{mouse: 1'b1, keyboard: 1'b1, kbc_line: 1'b1, default: 1'b0};
      cyc(3);
      rd_chk("status b follow", OFS_STATUS_B, 8'h13);
      reg_wr(OFS_STATUS_B, 8'hff);
      rd_chk("status b no w1c", OFS_STATUS_B, 8'h13);
      @(posedge sys_clk);
      src <= '0;
      cyc(3);
      rd_chk("status b cleared", OFS_STATUS_B, 8'h00);
      $display("test status b done");
   endtask

   task automatic t_ir();
      @(posedge sys_clk);
      ir_pri <= 1'b1;
      cyc(8);
      rd_chk("ir set", OFS_STATUS_B, 8'h04);
      rd_chk("ir read clear", OFS_STATUS_B, 8'h00);
      // unselected input must not count; equal levels keep the mux steady
      @(posedge sys_clk);
      ir_alt <= 1'b1;
      cyc(8);
      @(posedge sys_clk);
      ir_sel <= 1'b1;
      cyc(8);
      rd_chk("ir no edge", OFS_STATUS_B, 8'h00);
      @(posedge sys_clk);
      ir_alt <= 1'b0;
      cyc(8);
      rd_chk("ir alternate", OFS_STATUS_B, 8'h04);
      $display("test infrared done");
   endtask

   task automatic t_gpio();
      for (int k = 0; k < 3; k++) begin
         @(posedge sys_clk);
         evt[k] <= 8'hff;
         @(posedge sys_clk);
         evt[k] <= 8'h00;
         rd_chk("status latch", OFS_STATUS_C + 8'(k), smask[k]);
         reg_wr(OFS_STATUS_C + 8'(k), 8'h00);
         rd_chk("w1c zero", OFS_STATUS_C + 8'(k), smask[k]);
         cyc(1);
         chk1("group gated off", 1'b0, grp);
         @(posedge sys_clk);
         en_x[k] <= 8'h01;
         cyc(4);
         chk1("group gated on", 1'b1, grp);
         reg_wr(OFS_STATUS_C + 8'(k), 8'h0f);
         rd_chk("w1c part", OFS_STATUS_C + 8'(k), smask[k] & 8'hf0);
         cyc(3);
         chk1("group after clear", 1'b0, grp);
         reg_wr(OFS_STATUS_C + 8'(k), 8'hff);
         rd_chk("w1c all", OFS_STATUS_C + 8'(k), 8'h00);
         @(posedge sys_clk);
         en_x[k] <= 8'h00;
      end
      $display("test gpio status done");
   endtask

   task automatic t_route();
      reg_wr(OFS_ENABLE_B, 8'he1);
      cyc(3);
      outs(1'b0, 1'b0, 1'b0, 1'b1);
      @(posedge sys_clk);
      src.mouse <= 1'b1;
      cyc(4);
      outs(1'b1, 1'b1, 1'b1, 1'b1);
      reg_wr(OFS_ENABLE_B, 8'h01);
      cyc(3);
      outs(1'b1, 1'b0, 1'b0, 1'b0);
      reg_wr(OFS_ENABLE_B, 8'h00);
      cyc(3);
      chk1("group mouse off", 1'b0, grp);
      // each enable a gate against its own source only
      for (int i = 1; i <= 5; i++) begin
         @(posedge sys_clk);
         src <= smis_src_t'(8'h01 << (5 - i));
         reg_wr(OFS_ENABLE_A, ENABLE_A_MASK & ~(8'h01 << i));
         cyc(3);
         chk1("group a off", 1'b0, grp);
         reg_wr(OFS_ENABLE_A, 8'h01 << i);
         cyc(3);
         chk1("group a on", 1'b1, grp);
      end
      @(posedge sys_clk);
      src <= '0;
      reg_wr(OFS_ENABLE_A, 8'h00);
      $display("test routing done");
   endtask

   task automatic t_irq();
      reg_wr(OFS_EVT_STATUS, EVT_MASK);
      reg_wr(OFS_ENABLE_B, 8'h01);
      @(posedge sys_clk);
      src.mouse <= 1'b1;
      cyc(4);
      chk1("block irq masked", 1'b0, block_irq);
      rd_chk("event status", OFS_EVT_STATUS, 8'h01);
      reg_wr(OFS_EVT_MASK, 8'h01);
      cyc(3);
      chk1("block irq on", 1'b1, block_irq);
      reg_wr(OFS_EVT_STATUS, 8'h01);
      cyc(3);
      chk1("block irq cleared", 1'b0, block_irq);
      rd_chk("event status clear", OFS_EVT_STATUS, 8'h00);
      @(posedge sys_clk);
      src <= '0;
      reg_wr(OFS_ENABLE_B, 8'h00);
      $display("test block irq done");
   endtask

   // reset in mid-run with state loaded and the primary infrared pin idling high
   task automatic t_midreset();
      reg_wr(OFS_ENABLE_A, 8'hff);
      reg_wr(OFS_ENABLE_B, 8'hff);
      @(posedge sys_clk);
      evt[1] <= 8'hff;
      ir_sel <= 1'b0;
      @(posedge sys_clk);
      evt[1]  <= 8'h00;
      en_x[1] <= 8'hff;
      cyc(4);
      chk1("group before reset", 1'b1, grp);
      @(posedge sys_clk);
      reset   <= 1'b1;
      en_x[1] <= 8'h00;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      cyc(1);
      outs(1'b0, 1'b0, 1'b0, 1'b0);
      chk1("block irq reset", 1'b0, block_irq);
      for (int a = 8'h12; a <= 8'h17; a++) rd_chk("reset again", 8'(a), REG_RESET);
      rd_chk("event status reset", OFS_EVT_STATUS, REG_RESET);
      rd_chk("no false ir edge", OFS_STATUS_B, 8'h00);
      $display("test mid-run reset done");
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      cyc(1);
      t_reset();
      t_enables();
      t_status_b();
      t_ir();
      t_gpio();
      t_route();
      t_irq();
      t_midreset();
      summarize();
   end

   // watchdog, well beyond the roughly 315 cycles the tests need
   initial begin
      repeat (5000) @(posedge sys_clk);
      fails++;
      summarize();
   end
endmodule
`default_nettype wire
